// >>> src/i2cst_pkg.sv
// Shared constants, types and state codes of the I2C slave transmit and 10-bit address block
package i2cst_pkg;

  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  localparam int          BYTE_W       = 8;
  localparam int          CNT_W        = 4;
  localparam logic [3:0]  CNT_ZERO     = 4'h0;
  localparam logic [3:0]  CNT_ONE      = 4'h1;
  localparam logic [3:0]  CNT_BYTE     = 4'h8;
  localparam logic [3:0]  CNT_ACK      = 4'h9;
  localparam logic [4:0]  TEN_PREFIX   = 5'h1E;
  localparam logic [7:0]  OWN_ADDR_RST = 8'h00;
  localparam logic [7:0]  BUF_RST      = 8'h00;
  localparam int          FIFO_DEPTH_DEF = 16;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ten_bit_mode;
    logic address_hold_en;
    logic data_hold_en;
    logic stretch_enable;
    logic slave_collision_detect_en;
    logic start_irq_en;
    logic ack_value_bit;
  } i2cst_cfg_type;

  typedef struct packed {
    logic direction_flag;
    logic data_addr_flag;
    logic start_flag;
    logic stop_flag;
    logic address_update_flag;
    logic buffer_full_flag;
    logic ack_status_bit;
    logic ack_time_flag;
    logic clock_release_bit;
    logic serial_irq_flag;
    logic collision_irq_flag;
  } i2cst_status_type;

  // Clock released, everything else clear
  localparam i2cst_status_type STATUS_RST = '{clock_release_bit: 1'b1, default: 1'b0};

  // ----------------------------------------------------------------
  // Sequencer states and byte kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_ADDR2 = 3'h2,
    ST_ACK   = 3'h3,
    ST_RX    = 3'h4,
    ST_TX    = 3'h5,
    ST_TXACK = 3'h6
  } i2cst_state_type;

  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_LOW  = 2'h1,
    K_DATA = 2'h2
  } i2cst_kind_type;

endpackage : i2cst_pkg

// >>> src/i2cst_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module i2cst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             CLK_SYS,
  input  wire logic             NRST,
  input  wire logic [WIDTH-1:0] IN_DATA,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  output logic [WIDTH-1:0]      OUT_DATA,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY
);
  import i2cst_pkg::*;

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("FIFO depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire              empty = (wr_ptr == rd_ptr);
  wire              push  = IN_VALID && !full;
  wire              pop   = OUT_READY && !empty;

  assign IN_READY  = !full;
  assign OUT_VALID = !empty;
  assign OUT_DATA  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge CLK_SYS) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= IN_DATA;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
    end
  end

endmodule : i2cst_fifo

// >>> src/i2cst_slave.sv
// I2C slave: read-request transmission, slave collision, 10-bit addressing with address and data hold
//
// Operation
// - Matching read address sets direction, buffers, ACKs
// - After read ACK clear release bit, hold SCL
// - Buffer load fills shift register; software releases
// - Transmit bits change on SCL falling edges
// - Master ACK latched on ninth rising edge
// - NACK ends transfer, SCL free, flag, idle
// - Interrupt flag set on ninth falling edge
// - Enabled collision while transmitting sets flag, idles
// - Master ACK stretches SCL, raises interrupt flag
// - Address hold stretches after eighth falling edge
// - Address hold read ACK clears release, flags
// - Start sets start flag; interrupt if enabled
// - Matching high write byte sets update flag
// - Low address write releases SCL
// - Low mismatch still flags, no buffer full
// - Ten-bit data ACKed, flagged, optional stretch
// - Hold points in ten-bit equal seven-bit
// - High byte compared with 11110, A9, A8
// - Own-address write clears update flag immediately
`timescale 1ns/1ps
module i2cst_slave #(
  parameter int FIFO_DEPTH = i2cst_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic                       CLK_SYS,
  input  wire logic                       NRST,
  input  wire i2cst_pkg::i2cst_cfg_type   CFG,
  input  wire logic [7:0]                 TX_DATA,
  input  wire logic                       TX_VALID,
  output logic                            TX_READY,
  input  wire logic                       BUF_READ,
  input  wire logic                       RELEASE_SET,
  input  wire logic                       IRQ_CLEAR,
  input  wire logic                       COLLISION_CLEAR,
  input  wire logic                       OWN_ADDR_WR,
  input  wire logic [7:0]                 OWN_ADDR_DATA,
  output logic [7:0]                      SERIAL_BUFFER,
  output logic [7:0]                      OWN_ADDRESS_REG,
  output i2cst_pkg::i2cst_status_type     PORT_STATUS_REG,
  input  wire logic                       SCL_IN,
  output logic                            SCL_OUT,
  output logic                            SCL_OE,
  input  wire logic                       SDA_IN,
  output logic                            SDA_OUT,
  output logic                            SDA_OE
);
  import i2cst_pkg::*;

  generate
    if (FIFO_DEPTH < 2) begin : g_bad
      $error("FIFO_DEPTH must be at least 2");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------------------------------
  logic scl_m;
  logic scl_s;
  logic scl_q;
  logic sda_m;
  logic sda_s;
  logic sda_q;

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      {scl_m, scl_s, scl_q} <= 3'h7;
      {sda_m, sda_s, sda_q} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_q} <= {SCL_IN, scl_m, scl_s};
      {sda_m, sda_s, sda_q} <= {SDA_IN, sda_m, sda_s};
    end
  end

  wire scl_rise  = scl_s && !scl_q;
  wire scl_fall  = !scl_s && scl_q;
  wire start_det = scl_s && scl_q && sda_q && !sda_s;
  wire stop_det  = scl_s && scl_q && !sda_q && sda_s;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  i2cst_state_type  state;
  i2cst_state_type  next_state;
  i2cst_kind_type   kind;
  i2cst_kind_type   next_kind;
  i2cst_status_type stat;
  i2cst_status_type next_stat;
  logic [3:0]       cnt;
  logic [3:0]       next_cnt;
  logic [7:0]       shreg;
  logic [7:0]       next_shreg;
  logic [7:0]       buffer;
  logic [7:0]       next_buffer;
  logic [7:0]       own;
  logic [7:0]       next_own;
  logic             ack_low;
  logic             next_ack_low;
  logic             sw_ack;
  logic             next_sw_ack;
  logic             ten_ok;
  logic             next_ten_ok;
  logic             low_match;
  logic             next_low_match;
  logic             scl_hold;
  logic             next_scl_hold;

  // ----------------------------------------------------------------
  // Transmit queue in front of the serial buffer
  // ----------------------------------------------------------------
  logic [7:0] fifo_data;
  logic       fifo_valid;
  wire        load_window = (state == ST_TX) && (cnt == CNT_ZERO) && !stat.buffer_full_flag;
  wire        fifo_take   = fifo_valid && load_window;

  i2cst_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_txq (
    .CLK_SYS   (CLK_SYS),
    .NRST      (NRST),
    .IN_DATA   (TX_DATA),
    .IN_VALID  (TX_VALID),
    .IN_READY  (TX_READY),
    .OUT_DATA  (fifo_data),
    .OUT_VALID (fifo_valid),
    .OUT_READY (load_window)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit7     = (shreg[7:1] == own[7:1]);
  wire hit_hi   = (shreg[7:1] == {TEN_PREFIX, own[2:1]}) && (!shreg[0] || ten_ok);
  wire hit_low  = (shreg == own);
  wire hit_addr = CFG.ten_bit_mode ? hit_hi : hit7;
  // Software answer only counts when a hold gave it the chance to choose
  wire acked    = sw_ack ? !CFG.ack_value_bit : ack_low;
  wire tx_low   = (state == ST_TX) && !shreg[7];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_kind      = kind;
    next_stat      = stat;
    next_cnt       = cnt;
    next_shreg     = shreg;
    next_buffer    = buffer;
    next_own       = own;
    next_ack_low   = ack_low;
    next_sw_ack    = sw_ack;
    next_ten_ok    = ten_ok;
    next_low_match = low_match;
    // Software writes first so that a hardware update in the same cycle wins
    if (RELEASE_SET) begin
      next_stat.clock_release_bit = 1'b1;
    end
    if (IRQ_CLEAR) begin
      next_stat.serial_irq_flag = 1'b0;
    end
    if (COLLISION_CLEAR) begin
      next_stat.collision_irq_flag = 1'b0;
    end
    if (BUF_READ) begin
      next_stat.buffer_full_flag = 1'b0;
    end
    if (OWN_ADDR_WR) begin
      next_own                      = OWN_ADDR_DATA;
      next_stat.address_update_flag = 1'b0;
    end
    if (fifo_take) begin
      next_buffer                = fifo_data;
      next_shreg                 = fifo_data;
      next_stat.buffer_full_flag = 1'b1;
    end
    if (start_det) begin
      next_stat.start_flag = 1'b1;
      next_stat.stop_flag  = 1'b0;
      if (CFG.start_irq_en) begin
        next_stat.serial_irq_flag = 1'b1;
      end
      next_state = ST_ADDR;
      next_cnt   = CNT_ZERO;
    end else if (stop_det) begin
      next_stat.stop_flag  = 1'b1;
      next_stat.start_flag = 1'b0;
      next_ten_ok          = 1'b0;
      next_state           = ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_ADDR, ST_ADDR2, ST_RX: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt   = cnt + CNT_ONE;
          end
          if (scl_fall && cnt == CNT_BYTE) begin
            next_state = ST_ACK;
            if (state == ST_ADDR && !hit_addr) begin
              next_state = ST_IDLE;
            end else if (state == ST_ADDR2 && !hit_low) begin
              next_kind      = K_LOW;
              next_low_match = 1'b0;
              next_ack_low   = 1'b0;
              next_sw_ack    = 1'b0;
            end else begin
              next_kind                  = (state == ST_ADDR) ? K_ADDR : (state == ST_ADDR2) ? K_LOW : K_DATA;
              next_low_match             = (state == ST_ADDR2);
              next_buffer                = shreg;
              next_stat.buffer_full_flag = 1'b1;
              next_stat.data_addr_flag   = (state == ST_RX);
              // Read requests are always acknowledged, received bytes only without overflow
              next_ack_low               = (state == ST_ADDR && shreg[0]) || !stat.buffer_full_flag;
              if (state == ST_ADDR) begin
                next_stat.direction_flag = shreg[0];
              end
              next_sw_ack = (state == ST_RX) ? CFG.data_hold_en : CFG.address_hold_en;
              if (next_sw_ack) begin
                next_stat.clock_release_bit = 1'b0;
                next_stat.serial_irq_flag   = 1'b1;
                next_stat.ack_time_flag     = 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_rise) begin
            next_cnt = cnt + CNT_ONE;
          end
          if (scl_fall && cnt == CNT_ACK) begin
            next_stat.ack_time_flag = 1'b0;
            next_cnt                = CNT_ZERO;
            if (kind == K_LOW) begin
              next_stat.serial_irq_flag     = 1'b1;
              next_stat.address_update_flag = 1'b1;
              next_ten_ok                   = low_match && acked;
              next_state                    = (low_match && acked) ? ST_RX : ST_IDLE;
            end else if (!acked) begin
              next_state = ST_IDLE;
            end else begin
              next_stat.serial_irq_flag = 1'b1;
              if (kind == K_ADDR && stat.direction_flag) begin
                next_stat.clock_release_bit = 1'b0;
                next_state                  = ST_TX;
              end else if (kind == K_ADDR && CFG.ten_bit_mode) begin
                next_stat.address_update_flag = 1'b1;
                next_state                    = ST_ADDR2;
              end else begin
                if (CFG.stretch_enable) begin
                  next_stat.clock_release_bit = 1'b0;
                end
                next_state = ST_RX;
              end
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_cnt = cnt + CNT_ONE;
            if (!tx_low && !sda_s && CFG.slave_collision_detect_en) begin
              next_stat.collision_irq_flag = 1'b1;
              next_stat.clock_release_bit  = 1'b1;
              next_state                   = ST_IDLE;
            end
          end
          if (scl_fall && cnt != CNT_ZERO) begin
            if (cnt == CNT_BYTE) begin
              next_state                 = ST_TXACK;
              next_stat.buffer_full_flag = 1'b0;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            next_cnt                 = cnt + CNT_ONE;
            next_stat.ack_status_bit = sda_s;
          end
          if (scl_fall && cnt == CNT_ACK) begin
            next_stat.serial_irq_flag = 1'b1;
            next_cnt                  = CNT_ZERO;
            if (!stat.ack_status_bit) begin
              next_stat.clock_release_bit = 1'b0;
              next_state                  = ST_TX;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock stretching: wait for the bus low before holding it, so a hold
  // never shortens a high phase the master has already begun
  // ----------------------------------------------------------------
  wire hold_req = !stat.clock_release_bit || stat.address_update_flag;
  assign next_scl_hold = hold_req && (scl_hold || !scl_s);

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      state     <= ST_IDLE;
      kind      <= K_ADDR;
      stat      <= STATUS_RST;
      cnt       <= CNT_ZERO;
      shreg     <= BUF_RST;
      buffer    <= BUF_RST;
      own       <= OWN_ADDR_RST;
      ack_low   <= 1'b0;
      sw_ack    <= 1'b0;
      ten_ok    <= 1'b0;
      low_match <= 1'b0;
      scl_hold  <= 1'b0;
    end else begin
      state     <= next_state;
      kind      <= next_kind;
      stat      <= next_stat;
      cnt       <= next_cnt;
      shreg     <= next_shreg;
      buffer    <= next_buffer;
      own       <= next_own;
      ack_low   <= next_ack_low;
      sw_ack    <= next_sw_ack;
      ten_ok    <= next_ten_ok;
      low_match <= next_low_match;
      scl_hold  <= next_scl_hold;
    end
  end

  // ----------------------------------------------------------------
  // Pins and software view
  // ----------------------------------------------------------------
  wire ack_drive = (state == ST_ACK) && acked;

  assign SCL_OUT         = 1'b0;
  assign SDA_OUT         = 1'b0;
  assign SCL_OE          = scl_hold;
  assign SDA_OE          = ack_drive || tx_low;
  assign SERIAL_BUFFER   = buffer;
  assign OWN_ADDRESS_REG = own;
  assign PORT_STATUS_REG = stat;

endmodule : i2cst_slave

// >>> verif/i2cst_slave_props.sv
// Port-level checks of the I2C slave, bound to every instance
`timescale 1ns/1ps
module i2cst_slave_props #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic                        CLK_SYS,
  input wire logic                        NRST,
  input wire i2cst_pkg::i2cst_cfg_type    CFG,
  input wire logic                        RELEASE_SET,
  input wire logic                        BUF_READ,
  input wire logic                        OWN_ADDR_WR,
  input wire logic [7:0]                  OWN_ADDR_DATA,
  input wire logic [7:0]                  OWN_ADDRESS_REG,
  input wire i2cst_pkg::i2cst_status_type PORT_STATUS_REG,
  input wire logic                        SCL_IN,
  input wire logic                        SCL_OE,
  input wire logic                        SDA_OE
);
  import i2cst_pkg::*;
  wire crb = PORT_STATUS_REG.clock_release_bit;
  wire upd = PORT_STATUS_REG.address_update_flag;
  wire col = PORT_STATUS_REG.collision_irq_flag;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  a_hold_has_cause: assert property ($rose(SCL_OE) |-> !crb || upd)
    else $error("scl held without cause");
  a_hold_applied: assert property ((!crb && !SCL_IN) [*6] |-> SCL_OE)
    else $error("scl not held while release bit clear");
  a_release_on_set: assert property (RELEASE_SET |=> crb)
    else $error("release bit not set");
  a_own_addr_load: assert property (OWN_ADDR_WR |=> OWN_ADDRESS_REG == $past(OWN_ADDR_DATA))
    else $error("own address not loaded");
  a_upd_write_clears: assert property (OWN_ADDR_WR |=> !upd)
    else $error("update flag survived own address write");
  a_buf_read_clears: assert property (BUF_READ |=> !PORT_STATUS_REG.buffer_full_flag)
    else $error("buffer full not cleared by read");
  a_sda_steady_high: assert property ((SCL_IN [*6] ##0 !col) |-> $stable(SDA_OE))
    else $error("sda changed while scl high");
  a_ack_on_rise: assert property ($changed(PORT_STATUS_REG.ack_status_bit) |-> SCL_IN && $past(SCL_IN, 2))
    else $error("ack status changed outside scl high");
  a_irq_on_fall: assert property ($rose(PORT_STATUS_REG.serial_irq_flag) && !CFG.start_irq_en |-> !SCL_IN)
    else $error("interrupt flag set outside scl low");
  a_collision_idle: assert property ($rose(col) |-> crb && !SDA_OE)
    else $error("collision did not idle the slave");

  c_collision: cover property ($rose(col));
  c_update: cover property ($rose(upd));
  c_stretch: cover property ($fell(crb) ##[1:40] SCL_OE);
endmodule : i2cst_slave_props

bind i2cst_slave i2cst_slave_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .CFG(CFG), .RELEASE_SET(RELEASE_SET), .BUF_READ(BUF_READ),
  .OWN_ADDR_WR(OWN_ADDR_WR), .OWN_ADDR_DATA(OWN_ADDR_DATA), .OWN_ADDRESS_REG(OWN_ADDRESS_REG),
  .PORT_STATUS_REG(PORT_STATUS_REG), .SCL_IN(SCL_IN), .SCL_OE(SCL_OE), .SDA_OE(SDA_OE));

// >>> verif/i2cst_master_model.sv
// Behavioural I2C bus master: open-drain lines with pull-ups, honours stretching
`timescale 1ns/1ps
module i2cst_master_model (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output wire logic scl,
  output wire logic sda,
  output logic      stuck
);
  logic scl_low;
  logic sda_low;
  // Released lines float high through the pull-ups
  assign scl = !(scl_low || scl_oe);
  assign sda = !(sda_low || sda_oe);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stuck = 1'b0;
  end
  // A slave may stretch the low phase, so wait for the wire, not the timer
  task automatic rel_scl;
    int n;
    n = 0;
    scl_low = 1'b0;
    while (!scl && n < 20000) begin
      #8;
      n++;
    end
    if (!scl) stuck = 1'b1;
  endtask : rel_scl
  task automatic bit_io(input logic drv, output logic smp);
    sda_low = !drv;
    #31;
    rel_scl();
    #62;
    smp = sda;
    scl_low = 1'b1;
    #31;
  endtask : bit_io
  task automatic xfer8(input logic [7:0] o, output logic [7:0] i);
    for (int k = 7; k >= 0; k--) bit_io(o[k], i[k]);
  endtask : xfer8
  task automatic start;
    sda_low = 1'b1;
    #62;
    scl_low = 1'b1;
    #31;
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    #31;
    rel_scl();
    #62;
    sda_low = 1'b0;
    #62;
  endtask : stop
endmodule : i2cst_master_model

// >>> verif/tb_i2c_slave_tx_and_10bit_addr.sv
// Self-checking bench for the I2C slave transmit and 10-bit address block
`timescale 1ns/1ps
module tb_i2c_slave_tx_and_10bit_addr;
  import i2cst_pkg::*;
  logic             clk_sys, nrst, tx_valid, buf_read, rel_set, irq_clear, col_clear, own_wr, a;
  logic [7:0]       tx_data, own_data, sbuf, own_reg, d;
  wire              scl, sda, stuck, scl_oe, sda_oe, tx_ready, scl_out, sda_out;
  i2cst_cfg_type    cfg;
  i2cst_status_type st;
  int               bad_count, comparisons;

  i2cst_slave dut (.CLK_SYS(clk_sys), .NRST(nrst), .CFG(cfg), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .BUF_READ(buf_read), .RELEASE_SET(rel_set), .IRQ_CLEAR(irq_clear),
    .COLLISION_CLEAR(col_clear), .OWN_ADDR_WR(own_wr), .OWN_ADDR_DATA(own_data), .SERIAL_BUFFER(sbuf),
    .OWN_ADDRESS_REG(own_reg), .PORT_STATUS_REG(st), .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe));
  i2cst_master_model mst (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda), .stuck(stuck));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ------------------------------------------------------------
  // Software-side access tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // Mask order: buffer read, release clock, clear irq, clear collision
  // Both tasks first align to the clock, since the bus model returns at arbitrary times
  task automatic sw(input logic [3:0] m);
    cyc(1);
    {buf_read, rel_set, irq_clear, col_clear} = m;
    cyc(1);
    {buf_read, rel_set, irq_clear, col_clear} = 4'h0;
    cyc(1);
  endtask : sw
  task automatic own_w(input logic [7:0] v);
    cyc(1);
    own_data = v;
    own_wr = 1'b1;
    cyc(1);
    own_wr = 1'b0;
    cyc(1);
  endtask : own_w
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  always @(posedge stuck) begin
    bad_count++;
    final_report();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    cfg = '0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    {buf_read, rel_set, irq_clear, col_clear} = 4'h0;
    own_wr = 1'b0;
    own_data = 8'h00;
    bad_count = 0;
    comparisons = 0;
    cyc(3);
    nrst = 1'b1;
    cyc(4);
    chk("status", st, STATUS_RST);
    chk("own", own_reg, OWN_ADDR_RST);
    chk("buf", sbuf, BUF_RST);
    chk("pins", {scl_out, sda_out}, 2'h0);
    tx_valid = 1'b1;
    for (int i = 0; i < 16; i++) begin
      tx_data = 8'(8'hA0 + i);
      cyc(1);
    end
    tx_valid = 1'b0;
    chk("fifo full", tx_ready, 1'b0);
    $display("test reset and fill done");
    own_w(8'h52);
    mst.start();
    cyc(6);
    chk("start", st.start_flag, 1'b1);
    chk("irq", st.serial_irq_flag, 1'b0);
    mst.xfer8(8'h53, d);
    mst.bit_io(1'b1, a);
    cyc(6);
    chk("addr ack", a, 1'b0);
    chk("dir", st.direction_flag, 1'b1);
    chk("buf", sbuf, 8'h53);
    chk("irq", st.serial_irq_flag, 1'b1);
    chk("hold", scl_oe, 1'b1);
    sw(4'b1010);
    for (int i = 0; i < 16; i++) begin
      cyc(2);
      chk("load", sbuf, 8'(8'hA0 + i));
      chk("full", st.buffer_full_flag, 1'b1);
      sw(4'b0100);
      mst.xfer8(8'hFF, d);
      chk("data", d, 8'(8'hA0 + i));
      mst.bit_io(i == 15, a);
      cyc(6);
      chk("ack_status_bit", st.ack_status_bit, 1'(i == 15));
      chk("irq", st.serial_irq_flag, 1'b1);
      chk("release", st.clock_release_bit, 1'(i == 15));
      sw(4'b0010);
    end
    chk("hold", scl_oe, 1'b0);
    chk("drained", tx_ready, 1'b1);
    mst.stop();
    $display("test seven bit read done");
    cyc(1);
    cfg.address_hold_en = 1'b1;
    cfg.slave_collision_detect_en = 1'b1;
    mst.start();
    mst.xfer8(8'h53, d);
    cyc(6);
    chk("ack time", st.ack_time_flag, 1'b1);
    chk("release", st.clock_release_bit, 1'b0);
    chk("irq", st.serial_irq_flag, 1'b1);
    sw(4'b1010);
    sw(4'b0100);
    mst.bit_io(1'b1, a);
    cyc(6);
    chk("addr ack", a, 1'b0);
    chk("ack time", st.ack_time_flag, 1'b0);
    chk("release", st.clock_release_bit, 1'b0);
    chk("irq", st.serial_irq_flag, 1'b1);
    sw(4'b0010);
    tx_data = 8'hFF;
    tx_valid = 1'b1;
    cyc(1);
    tx_valid = 1'b0;
    cyc(2);
    sw(4'b0100);
    mst.bit_io(1'b0, a);
    cyc(6);
    chk("collision", st.collision_irq_flag, 1'b1);
    chk("release", st.clock_release_bit, 1'b1);
    chk("sda free", sda_oe, 1'b0);
    sw(4'b1001);
    mst.stop();
    $display("test address hold and collision done");
    cyc(1);
    cfg = '0;
    cfg.ten_bit_mode = 1'b1;
    own_w(8'h06);
    mst.start();
    mst.xfer8(8'hF6, d);
    mst.bit_io(1'b1, a);
    cyc(6);
    chk("high ack", a, 1'b0);
    chk("update", st.address_update_flag, 1'b1);
    chk("irq", st.serial_irq_flag, 1'b1);
    chk("hold", scl_oe, 1'b1);
    sw(4'b1010);
    own_w(8'h34);
    chk("update", st.address_update_flag, 1'b0);
    chk("own", own_reg, 8'h34);
    cyc(1);
    chk("free", scl_oe, 1'b0);
    mst.xfer8(8'h77, d);
    mst.bit_io(1'b1, a);
    cyc(6);
    chk("low nack", a, 1'b1);
    chk("update", st.address_update_flag, 1'b1);
    chk("irq", st.serial_irq_flag, 1'b1);
    chk("full", st.buffer_full_flag, 1'b0);
    chk("release", st.clock_release_bit, 1'b1);
    sw(4'b0010);
    own_w(8'h06);
    mst.stop();
    cyc(6);
    chk("stop", st.stop_flag, 1'b1);
    cfg.start_irq_en = 1'b1;
    cfg.stretch_enable = 1'b1;
    mst.start();
    cyc(6);
    chk("start irq", st.serial_irq_flag, 1'b1);
    sw(4'b0010);
    mst.xfer8(8'hF6, d);
    mst.bit_io(1'b1, a);
    cyc(6);
    sw(4'b1010);
    own_w(8'h34);
    mst.xfer8(8'h34, d);
    mst.bit_io(1'b1, a);
    cyc(6);
    chk("low ack", a, 1'b0);
    chk("full", st.buffer_full_flag, 1'b1);
    sw(4'b1010);
    own_w(8'h06);
    cfg.data_hold_en = 1'b1;
    mst.xfer8(8'hC3, d);
    cyc(6);
    chk("data hold", st.ack_time_flag, 1'b1);
    chk("irq", st.serial_irq_flag, 1'b1);
    chk("release", st.clock_release_bit, 1'b0);
    sw(4'b0110);
    mst.bit_io(1'b1, a);
    cyc(6);
    chk("data ack", a, 1'b0);
    chk("rx", sbuf, 8'hC3);
    chk("irq", st.serial_irq_flag, 1'b1);
    chk("release", st.clock_release_bit, 1'b0);
    chk("data flag", st.data_addr_flag, 1'b1);
    chk("ack time", st.ack_time_flag, 1'b0);
    sw(4'b1110);
    mst.stop();
    $display("test ten bit address done");
    final_report();
  end
endmodule : tb_i2c_slave_tx_and_10bit_addr
